/* File: design/rte_rotate_exec.sv */
// Rotate instruction execution: operand fetch, rotate, write-back, registers
//
// What this block does
// - Rotate left without carry: bit 7 wraps to bit 0, carry untouched.
// - Rotate right through carry: carry acts as ninth bit of rotation.
// - Destination bit 0: result goes to accumulator, source register unchanged.
// - Destination bit 1: result written back to the source data register.
// - Access bit 0: address resolved in fixed access bank unless the indexed case below applies, bank select ignored.
// - Access bit 1: bank select register joined with 8-bit address field.
// - Extended mode, access bit 0, address 5Fh or below: indexed literal offset.
`timescale 1ns/1ps
`default_nettype none
`include "rte_params.svh"

module rte_rotate_exec
  import rte_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Instruction issue
  input wire logic instr_valid,
  input wire logic instr_op,
  input wire logic instr_dest,
  input wire logic instr_access,
  input wire logic [7:0] instr_faddr,
  output logic instr_ready,
  // Data memory
  output logic [11:0] mem_addr,
  output logic mem_rd,
  input wire logic [7:0] mem_rdata,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  // Core state
  output logic [7:0] acc_out,
  output logic carry_out
);

  rte_state_t state;
  rte_state_t next_state;
  logic ext_enable;
  logic [3:0] bank_select_reg;
  logic [11:0] index_base;
  logic zero_flag;
  logic neg_flag;
  logic op_right;
  logic dest_mem;

  wire issue;
  wire indexed;
  wire [11:0] access_addr;
  wire [11:0] bank_addr;
  wire [11:0] index_addr;
  wire [11:0] eff_addr;
  wire [7:0] rot_result;
  wire rot_carry;
  wire rot_zero;
  wire rot_neg;
  wire exec_now;
  wire acc_from_instr;
  wire wr_ctrl;
  wire wr_bank;
  wire wr_acc;
  wire wr_flags;
  wire wr_index;
  wire [15:0] rd_mux;
  wire busy;

  // Address formation
  assign issue = instr_valid && instr_ready;
  assign indexed = ext_enable && !instr_access && (instr_faddr <= `RTE_INDEXED_TOP);
  assign access_addr = (instr_faddr <= `RTE_INDEXED_TOP) ?
                       {`RTE_ACCESS_LOW_BANK, instr_faddr} :
                       {`RTE_ACCESS_HIGH_BANK, instr_faddr};
  assign bank_addr = {bank_select_reg, instr_faddr};
  assign index_addr = index_base + {4'h0, instr_faddr};
  assign eff_addr = instr_access ? bank_addr : (indexed ? index_addr : access_addr);

  // Sequencing
  always_comb begin
    case (state)
      RTE_IDLE: next_state = issue ? RTE_READ : RTE_IDLE;
      RTE_READ: next_state = RTE_EXEC;
      RTE_EXEC: next_state = RTE_IDLE;
      default: next_state = RTE_IDLE;
    endcase
  end

  // Execute cycle: operand on the bus, result and flags land at its end
  assign exec_now = (state == RTE_EXEC);
  assign acc_from_instr = exec_now && !dest_mem;
  assign busy = !instr_ready;

  // Operand is taken straight off the memory bus in the execute cycle
  rte_rotate_unit u_rotate (
    .op_right(op_right),
    .operand(mem_rdata),
    .carry_in(carry_out),
    .result(rot_result),
    .carry_next(rot_carry),
    .zero_next(rot_zero),
    .neg_next(rot_neg)
  );

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= RTE_IDLE;
      instr_ready <= 1'b1;
      mem_rd <= 1'b0;
    end else begin
      state <= next_state;
      instr_ready <= (next_state == RTE_IDLE);
      mem_rd <= issue;
    end
  end

  // Fields captured at issue; the address stays put so write-back hits the same byte
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      op_right <= 1'b0;
      dest_mem <= 1'b0;
      mem_addr <= 12'h000;
    end else if (issue) begin
      op_right <= (instr_op == RTE_OP_ROTATE_RIGHT_THRU_CARRY);
      dest_mem <= instr_dest;
      mem_addr <= eff_addr;
    end
  end

  // Write-back; same register address keeps read and write paired
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_wr <= 1'b0;
      mem_wdata <= 8'h00;
    end else begin
      mem_wr <= exec_now && dest_mem;
      if (exec_now && dest_mem) begin
        mem_wdata <= rot_result;
      end
    end
  end

  // Register decode
  assign wr_ctrl = reg_wr && (reg_addr == `RTE_REG_CTRL);
  assign wr_bank = reg_wr && (reg_addr == `RTE_REG_BANK);
  assign wr_acc = reg_wr && (reg_addr == `RTE_REG_ACC);
  assign wr_flags = reg_wr && (reg_addr == `RTE_REG_FLAGS);
  assign wr_index = reg_wr && (reg_addr == `RTE_REG_INDEX);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_enable <= `RTE_CTRL_RESET;
      bank_select_reg <= `RTE_BANK_RESET;
      index_base <= `RTE_INDEX_RESET;
    end else begin
      if (wr_ctrl) begin
        ext_enable <= reg_wdata[`RTE_CTRL_EXT_BIT];
      end
      if (wr_bank) begin
        bank_select_reg <= reg_wdata[3:0];
      end
      if (wr_index) begin
        index_base <= reg_wdata[11:0];
      end
    end
  end

  // Accumulator: an instruction result wins over a software write in the same cycle
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_out <= `RTE_ACC_RESET;
    end else if (acc_from_instr) begin
      acc_out <= rot_result;
    end else if (wr_acc) begin
      acc_out <= reg_wdata[7:0];
    end
  end

  // Flags: a left rotate passes the carry through unchanged
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      carry_out <= 1'b0;
      zero_flag <= 1'b0;
      neg_flag <= 1'b0;
    end else if (exec_now) begin
      carry_out <= rot_carry;
      zero_flag <= rot_zero;
      neg_flag <= rot_neg;
    end else if (wr_flags) begin
      carry_out <= reg_wdata[`RTE_FLAG_C_BIT];
      zero_flag <= reg_wdata[`RTE_FLAG_Z_BIT];
      neg_flag <= reg_wdata[`RTE_FLAG_N_BIT];
    end
  end

  // Read data, one cycle after the strobe; unmapped reads zero
  assign rd_mux = (reg_addr == `RTE_REG_CTRL) ? {15'h0000, ext_enable} :
                  (reg_addr == `RTE_REG_BANK) ? {12'h000, bank_select_reg} :
                  (reg_addr == `RTE_REG_ACC) ? {8'h00, acc_out} :
                  (reg_addr == `RTE_REG_FLAGS) ? {13'h0000, neg_flag, zero_flag, carry_out} :
                  (reg_addr == `RTE_REG_INDEX) ? {4'h0, index_base} :
                  (reg_addr == `RTE_REG_STAT) ? {mem_addr, 3'h0, busy} :
                  16'h0000;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 16'h0000;
    end
  end

endmodule : rte_rotate_exec

`default_nettype wire

/* File: design/rte_params.svh */
// Register offsets, field positions, reset values and address constants
`ifndef RTE_PARAMS_SVH
`define RTE_PARAMS_SVH

`define RTE_REG_CTRL 4'h0
`define RTE_REG_BANK 4'h1
`define RTE_REG_ACC 4'h2
`define RTE_REG_FLAGS 4'h3
`define RTE_REG_INDEX 4'h4
`define RTE_REG_STAT 4'h5

`define RTE_CTRL_EXT_BIT 0
`define RTE_FLAG_C_BIT 0
`define RTE_FLAG_Z_BIT 1
`define RTE_FLAG_N_BIT 2
`define RTE_STAT_BUSY_BIT 0

`define RTE_CTRL_RESET 1'h0
`define RTE_BANK_RESET 4'h0
`define RTE_ACC_RESET 8'h00
`define RTE_INDEX_RESET 12'h000

`define RTE_INDEXED_TOP 8'h5F
`define RTE_ACCESS_LOW_BANK 4'h0
`define RTE_ACCESS_HIGH_BANK 4'hF

`endif

/* File: design/rte_pkg.sv */
// Types shared by the rotate execution block
package rte_pkg;

  typedef enum logic [2:0] {
    RTE_IDLE = 3'b001,
    RTE_READ = 3'b010,
    RTE_EXEC = 3'b100
  } rte_state_t;

  typedef enum logic {
    RTE_OP_ROTATE_LEFT_NOCARRY = 1'b0,
    RTE_OP_ROTATE_RIGHT_THRU_CARRY = 1'b1
  } rte_op_t;

endpackage : rte_pkg

/* File: design/rte_rotate_unit.sv */
// Combinational rotate datapath with carry and result flags
`timescale 1ns/1ps
`default_nettype none

module rte_rotate_unit
  import rte_pkg::*;
(
  // Operation and operand
  input wire logic op_right,
  input wire logic [7:0] operand,
  input wire logic carry_in,
  // Result
  output logic [7:0] result,
  output logic carry_next,
  output logic zero_next,
  output logic neg_next
);

  wire [7:0] left_result;
  wire [7:0] right_result;

  assign left_result = {operand[6:0], operand[7]};
  assign right_result = {carry_in, operand[7:1]};

  assign result = op_right ? right_result : left_result;
  assign carry_next = op_right ? operand[0] : carry_in;
  assign zero_next = (result == 8'h00);
  assign neg_next = result[7];

endmodule : rte_rotate_unit

`default_nettype wire

/* File: bench/rte_rotate_exec_assertions.sv */
// Concurrent checks on the rotate execution ports
`timescale 1ns/1ps
`default_nettype none
module rte_rotate_exec_assertions (
  input wire logic core_clk, sys_rst, instr_valid, instr_op, instr_dest, instr_access,
  input wire logic [7:0] instr_faddr,
  input wire logic instr_ready, mem_rd, mem_wr, carry_out,
  input wire logic [11:0] mem_addr,
  input wire logic [7:0] mem_rdata, mem_wdata, acc_out
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic [7:0] rd_q;
  logic op_q, dest_q;
  wire iss = instr_valid && instr_ready;
  always_ff @(posedge core_clk) begin
    rd_q <= mem_rdata;
    if (iss) begin
      op_q <= instr_op;
      dest_q <= instr_dest;
    end
  end
  property p_dest; iss |=> mem_rd ##2 mem_wr == $past(instr_dest, 3) && instr_ready; endproperty
  a_dest: assert property (p_dest) else $error("bad write-back timing");
  property p_left; mem_wr && !op_q |-> mem_wdata == {rd_q[6:0], rd_q[7]}; endproperty
  a_left: assert property (p_left) else $error("bad left rotate");
  property p_right;
    mem_wr && op_q |-> mem_wdata == {$past(carry_out), rd_q[7:1]} && carry_out == rd_q[0];
  endproperty
  a_right: assert property (p_right) else $error("bad right rotate");
  property p_acc;
    $rose(instr_ready) && !dest_q |->
      acc_out == (op_q ? {$past(carry_out), rd_q[7:1]} : {rd_q[6:0], rd_q[7]});
  endproperty
  a_acc: assert property (p_acc) else $error("bad accumulator result");
  property p_keep; mem_wr |-> $stable(acc_out) && mem_addr == $past(mem_addr, 2); endproperty
  a_keep: assert property (p_keep) else $error("bad write-back target");
  property p_bank; iss && instr_access |=> mem_addr[7:0] == $past(instr_faddr); endproperty
  a_bank: assert property (p_bank) else $error("bad banked address");
  property p_hi;
    iss && !instr_access && instr_faddr > 8'h5F |=> mem_addr == {4'hF, $past(instr_faddr)};
  endproperty
  a_hi: assert property (p_hi) else $error("bad access bank address");
  property p_lcar; $rose(instr_ready) && !op_q |-> $stable(carry_out); endproperty
  a_lcar: assert property (p_lcar) else $error("left rotate moved carry");
endmodule : rte_rotate_exec_assertions
`default_nettype wire

/* File: bench/rte_mem_model.sv */
// Data memory model with one-cycle read latency
`timescale 1ns/1ps
`default_nettype none
module rte_mem_model (
  input wire logic core_clk,
  input wire logic [11:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] ram [0:4095];
  logic [7:0] junk = 8'h5A;
  initial for (int i = 0; i < 4096; i++) ram[i] = 8'(i * 7 + 3);
  always @(posedge core_clk) begin
    junk <= ~junk;
    if (mem_wr) ram[mem_addr] <= mem_wdata;
    mem_rdata <= mem_rd ? ram[mem_addr] : junk;
  end
endmodule : rte_mem_model
`default_nettype wire

/* File: bench/rotate_instruction_exec_test.sv */
// Self-checking bench for the rotate execution block
`timescale 1ns/1ps
`default_nettype none
`include "rte_params.svh"
module rotate_instruction_exec_test;
  logic core_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, instr_valid = 0, instr_op = 0;
  logic instr_dest = 0, instr_access = 0, instr_ready, mem_rd, mem_wr, carry_out;
  logic [3:0] reg_addr = 0, bank = 0;
  logic [15:0] reg_wdata = 0, reg_rdata;
  logic [7:0] instr_faddr = 0, mem_rdata, mem_wdata, acc_out, acc = 0;
  logic [11:0] mem_addr, idx = 0;
  logic ext = 0, cy = 0;
  int seed = 13, fails = 0, checked = 0, cycles = 0;
  rte_rotate_exec uut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .instr_valid(instr_valid), .instr_op(instr_op), .instr_dest(instr_dest),
    .instr_access(instr_access), .instr_faddr(instr_faddr), .instr_ready(instr_ready),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .acc_out(acc_out), .carry_out(carry_out));
  rte_mem_model mem (.core_clk(core_clk), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  initial forever #4 core_clk = ~core_clk;
  task automatic tally_and_finish();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 6000) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    checked++;
    if (s !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : chk
  function automatic logic [11:0] ea(logic a, logic [7:0] f);
    return a ? {bank, f} : f > 8'h5F ? {4'hF, f} : ext ? idx + {4'h0, f} : {4'h0, f};
  endfunction : ea
  function automatic logic [8:0] rot(logic op, logic [7:0] x);
    return op ? {x[0], cy, x[7:1]} : {cy, x[6:0], x[7]};
  endfunction : rot
  task automatic wr(logic [3:0] a, logic [15:0] d);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk) reg_wr <= 0;
    @(posedge core_clk);
  endtask : wr
  task automatic rd(logic [3:0] a, logic [15:0] x);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge core_clk) reg_rd <= 0;
    #1 chk("reg_rdata", x, reg_rdata);
    @(posedge core_clk);
  endtask : rd
  task automatic cfg(logic e, logic [3:0] b, logic [11:0] i, logic [2:0] fl, logic [7:0] w);
    ext = e;
    bank = b;
    idx = i;
    cy = fl[0];
    acc = w;
    wr(`RTE_REG_CTRL, {15'h0, e});
    wr(`RTE_REG_BANK, {12'h0, b});
    wr(`RTE_REG_INDEX, {4'h0, i});
    wr(`RTE_REG_FLAGS, {13'h0, fl});
    wr(`RTE_REG_ACC, {8'h0, w});
    rd(`RTE_REG_CTRL, {15'h0, e});
    rd(`RTE_REG_BANK, {12'h0, b});
    rd(`RTE_REG_INDEX, {4'h0, i});
    rd(`RTE_REG_FLAGS, {13'h0, fl});
    rd(`RTE_REG_ACC, {8'h0, w});
  endtask : cfg
  task automatic instr(logic op, logic d, logic a, logic [7:0] f);
    logic [11:0] e;
    logic [8:0] r;
    e = ea(a, f);
    r = rot(op, mem.ram[e]);
    instr_valid <= 1;
    instr_op <= op;
    instr_dest <= d;
    instr_access <= a;
    instr_faddr <= f;
    @(posedge core_clk) instr_valid <= 0;
    #1 chk("mem_addr", e, mem_addr);
    repeat (2) @(posedge core_clk);
    #1 if (!d) acc = r[7:0];
    cy = r[8];
    chk("carry_out", cy, carry_out);
    chk("acc_out", acc, acc_out);
    chk("mem_wr", d, mem_wr);
    if (d) chk("mem_wdata", r[7:0], mem_wdata);
    @(posedge core_clk);
    rd(`RTE_REG_FLAGS, {13'h0, r[7], r[7:0] == 8'h00, r[8]});
    rd(`RTE_REG_STAT, {e, 4'h0});
  endtask : instr
  initial begin
    repeat (2) @(posedge core_clk);
    sys_rst <= 0;
    #1 chk("acc_out", 0, acc_out);
    chk("instr_ready", 1, instr_ready);
    @(posedge core_clk);
    rd(4'hF, 0);
    cfg(1, 4'h3, 12'hFF0, 3'h1, 8'hA5);
    instr(0, 1, 0, 8'h5F);
    instr(1, 0, 0, 8'h60);
    instr(1, 1, 1, 8'hFF);
    repeat (40) begin
      cfg(1'($random(seed)), 4'($random(seed)), 12'($random(seed)),
        3'($random(seed)), 8'($random(seed)));
      instr(1'($random(seed)), 1'($random(seed)), 1'($random(seed)), 8'($random(seed)));
    end
    sys_rst <= 1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 0;
    #1 chk("acc_out", 0, acc_out);
    chk("carry_out", 0, carry_out);
    chk("mem_addr", 0, mem_addr);
    chk("mem_wr", 0, mem_wr);
    chk("mem_rd", 0, mem_rd);
    chk("reg_rdata", 0, reg_rdata);
    chk("instr_ready", 1, instr_ready);
    ext = 0;
    bank = 0;
    idx = 0;
    acc = 0;
    cy = 0;
    @(posedge core_clk);
    instr(1, 0, 0, 8'h10);
    rd(`RTE_REG_ACC, {8'h0, acc});
    tally_and_finish();
  end
endmodule : rotate_instruction_exec_test
bind rte_rotate_exec rte_rotate_exec_assertions chk_u (.core_clk(core_clk), .sys_rst(sys_rst),
  .instr_valid(instr_valid), .instr_op(instr_op), .instr_dest(instr_dest),
  .instr_access(instr_access), .instr_faddr(instr_faddr), .instr_ready(instr_ready),
  .mem_rd(mem_rd), .mem_wr(mem_wr), .carry_out(carry_out), .mem_addr(mem_addr),
  .mem_rdata(mem_rdata), .mem_wdata(mem_wdata), .acc_out(acc_out));
`default_nettype wire
